// >>> dv/bus_fault_status_flags_test.sv
/*
  self-checking bench for the bus fault status flags block: flag set and
  clear, fault address loading, pending imprecise faults and the irq.
  assumes the bfs_pkg package and the design files are compiled first.
*/
module bus_fault_status_flags_test import bfs_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  // ************************************************************
  // signals and expected masks
  // ************************************************************
  localparam logic [31:0] M_IMP = 32'h0000_0001 << BIT_IMPRECISE;
  localparam logic [31:0] M_PRE = 32'h0000_0001 << BIT_PRECISE;
  localparam logic [31:0] M_INSTR_FETCH_ERR_FLAG = 32'h0000_0001 << BIT_INSTR_FETCH_ERR_FLAG;
  localparam logic [31:0] M_MMAV = 32'h0000_0001 << BIT_MMAV;
  logic clk, sys_rst, avs_read, avs_write, avs_waitrequest, imprecise_err, precise_err;
  logic prefetch_err, issue_valid, mm_fault, ctx_above_bf, handler_enter;
  logic bf_activate, stack_pc_faulting, irq;
  logic [3:0] avs_address, avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata, precise_addr, mm_addr, rd;
  int n_mismatch, compares, cycles, waits;

  bfs_fault_status dut (.CLK(clk), .SYS_RST(sys_rst), .AVS_ADDRESS(avs_address),
    .AVS_READ(avs_read), .AVS_WRITE(avs_write), .AVS_WRITEDATA(avs_writedata),
    .AVS_BYTEENABLE(avs_byteenable), .AVS_READDATA(avs_readdata),
    .AVS_WAITREQUEST(avs_waitrequest), .IMPRECISE_ERR(imprecise_err),
    .PRECISE_ERR(precise_err), .PRECISE_ADDR(precise_addr), .PREFETCH_ERR(prefetch_err),
    .ISSUE_VALID(issue_valid), .MM_FAULT(mm_fault), .MM_ADDR(mm_addr),
    .CTX_ABOVE_BF(ctx_above_bf), .HANDLER_ENTER(handler_enter), .BF_ACTIVATE(bf_activate),
    .STACK_PC_FAULTING(stack_pc_faulting), .IRQ(irq));

  // ************************************************************
  // clock, timeout and shared tasks
  // ************************************************************
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // cut a hang short well past the expected run length
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_mismatch++;
      close_out();
    end
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  task automatic close_out;
    if (n_mismatch == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // one avalon transfer, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
                     input logic [3:0] be);
    @(posedge clk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    avs_byteenable <= be;
    waits = 0;
    // only the bench timeout ends a wait that never finishes
    @(posedge clk);
    while (avs_waitrequest !== 1'b0) begin
      @(posedge clk);
      waits++;
    end
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 4'hF);
  endtask
  task automatic rdc(input logic [3:0] a, input logic [31:0] exp, input string what);
    bus(1'b0, a, 32'h0000_0000, 4'hF);
    check(rd, exp, what);
  endtask
  // one-cycle event pulses: imprecise, precise, prefetch, issue, mm
  task automatic ev(input logic [4:0] m, input logic [31:0] addr);
    @(posedge clk);
    {imprecise_err, precise_err, prefetch_err, issue_valid, mm_fault} <= m;
    precise_addr <= addr;
    mm_addr <= addr;
    @(posedge clk);
    {imprecise_err, precise_err, prefetch_err, issue_valid, mm_fault} <= 5'h00;
  endtask
  task automatic wait_active;
    int w;
    w = 0;
    while (bf_activate !== 1'b1 && w < 8) begin
      @(posedge clk);
      w++;
    end
  endtask
  task automatic enter_handler;
    @(posedge clk);
    handler_enter <= 1'b1;
    @(posedge clk);
    handler_enter <= 1'b0;
    @(posedge clk);
  endtask

  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic t_reset;
    rdc(OFS_FAULT_STAT, RST_WORD, "status reset");
    check(32'(waits), 32'h0000_0001, "read wait states");
    rdc(OFS_BF_ADDR, RST_WORD, "bf addr reset");
    rdc(OFS_MM_ADDR, RST_WORD, "mm addr reset");
    rdc(4'h1, UNMAPPED_READ, "unmapped read");
    check(32'({irq, bf_activate}), 32'h0000_0000, "outputs reset");
  endtask
  task automatic t_pending;
    ctx_above_bf <= 1'b1;
    ev(5'h10, 32'hA5A5_0000);
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      check(32'(bf_activate), 32'h0000_0000, "active while higher ctx");
    end
    ev(5'h08, 32'h2000_0040);
    rdc(OFS_FAULT_STAT, M_IMP | M_PRE, "both flags set");
    ctx_above_bf <= 1'b0;
    wait_active();
    check(32'(bf_activate), 32'h0000_0001, "active after return");
    enter_handler();
    check(32'(bf_activate), 32'h0000_0000, "handler entered");
    rdc(OFS_FAULT_STAT, M_IMP | M_PRE, "flags sticky");
    wr(OFS_FAULT_STAT, M_IMP);
    check(32'(waits), 32'h0000_0000, "write wait states");
    rdc(OFS_FAULT_STAT, M_PRE, "imprecise cleared");
    wr(OFS_FAULT_STAT, M_PRE);
  endtask
  task automatic t_precise;
    ev(5'h08, 32'h1234_5678);
    @(negedge clk);
    check(32'(stack_pc_faulting), 32'h0000_0001, "stack pc pulse");
    @(negedge clk);
    check(32'(stack_pc_faulting), 32'h0000_0000, "stack pc one cycle");
    rdc(OFS_FAULT_STAT, M_PRE, "precise flag");
    rdc(OFS_BF_ADDR, 32'h1234_5678, "fault addr");
    ev(5'h08, 32'hCAFE_0010);
    rdc(OFS_BF_ADDR, 32'hCAFE_0010, "fault addr reload");
    ev(5'h10, 32'h5555_0004);
    rdc(OFS_BF_ADDR, 32'hCAFE_0010, "imprecise no load");
    enter_handler();
    ev(5'h04, 32'h7777_0000);
    rdc(OFS_FAULT_STAT, M_PRE | M_IMP, "prefetch alone");
    ev(5'h02, 32'h6666_0000);
    rdc(OFS_FAULT_STAT, M_PRE | M_IMP | M_INSTR_FETCH_ERR_FLAG, "issue sets flag");
    rdc(OFS_BF_ADDR, 32'hCAFE_0010, "instr_fetch_err_flag no load");
    bus(1'b1, OFS_FAULT_STAT, 32'hFFFF_FFFF, 4'h0);
    rdc(OFS_FAULT_STAT, M_PRE | M_IMP | M_INSTR_FETCH_ERR_FLAG, "no byte enable");
    wr(OFS_FAULT_STAT, 32'h0000_0000);
    rdc(OFS_FAULT_STAT, M_PRE | M_IMP | M_INSTR_FETCH_ERR_FLAG, "zero write");
    wr(OFS_FAULT_STAT, M_INSTR_FETCH_ERR_FLAG);
    rdc(OFS_FAULT_STAT, M_PRE | M_IMP, "single clear");
    wr(OFS_FAULT_STAT, M_PRE | M_IMP);
    rdc(OFS_FAULT_STAT, RST_WORD, "all cleared");
  endtask
  task automatic t_mmav;
    ev(5'h01, 32'h0000_BEE0);
    rdc(OFS_FAULT_STAT, M_MMAV, "mm valid set");
    rdc(OFS_MM_ADDR, 32'h0000_BEE0, "mm addr");
    bus(1'b1, OFS_FAULT_STAT, M_MMAV, 4'h2);
    rdc(OFS_FAULT_STAT, M_MMAV, "wrong byte lane");
    bus(1'b1, OFS_FAULT_STAT, M_MMAV, 4'h1);
    rdc(OFS_FAULT_STAT, RST_WORD, "mm valid cleared");
  endtask
  task automatic t_irq;
    wr(OFS_IRQ_STAT, 32'h0000_0003);
    wr(OFS_BF_ADDR, 32'h0000_0003);
    ev(5'h10, 32'h0000_0000);
    wait_active();
    rdc(OFS_IRQ_STAT, 32'h0000_0003, "irq status");
    check(32'(irq), 32'h0000_0001, "irq raised");
    wr(OFS_BF_ADDR, 32'h0000_0000);
    @(posedge clk);
    check(32'(irq), 32'h0000_0000, "irq masked");
    wr(OFS_BF_ADDR, 32'h0000_0003);
    wr(OFS_IRQ_STAT, 32'h0000_0003);
    rdc(OFS_IRQ_STAT, 32'h0000_0000, "irq cleared");
    check(32'(irq), 32'h0000_0000, "irq low");
    enter_handler();
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    rdc(OFS_FAULT_STAT, RST_WORD, "reset clears flag");
  endtask

  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    {sys_rst, avs_read, avs_write, imprecise_err, precise_err} = 5'h10;
    {prefetch_err, issue_valid, mm_fault, ctx_above_bf, handler_enter} = 5'h00;
    avs_address = 4'h0;
    avs_byteenable = 4'hF;
    avs_writedata = 32'h0000_0000;
    precise_addr = 32'h0000_0000;
    mm_addr = 32'h0000_0000;
    n_mismatch = 0;
    compares = 0;
    cycles = 0;
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    t_reset();
    t_pending();
    t_precise();
    t_mmav();
    t_irq();
    close_out();
  end
endmodule

// >>> include/bfs_flag_if.sv
/*
  interface carrying flag state and clear strobes between the top and
  the flag bank. assumes both ends run on the same clock.
*/
interface bfs_flag_if;
  logic [3:0] set_evt;
  logic [3:0] clr_w1c;
  logic [3:0] flags;
  modport bank (input set_evt, input clr_w1c, output flags);
  modport top (output set_evt, output clr_w1c, input flags);
endinterface

// >>> include/bfs_pkg.sv
/*
  package for the bus fault status flags block: register offsets, bit
  positions, reset values and the pending-state enumeration.
  assumes a single 25 MHz core clock and a synchronous active-high reset.
*/
package bfs_pkg;
  // ************************************************************
  // register map (byte addresses, one aligned word each)
  // ************************************************************
  localparam logic [3:0] OFS_FAULT_STAT = 4'h0;
  localparam logic [3:0] OFS_BF_ADDR = 4'h4;
  localparam logic [3:0] OFS_MM_ADDR = 4'h8;
  localparam logic [3:0] OFS_IRQ_STAT = 4'hC;
  // ************************************************************
  // field positions and reset values
  // ************************************************************
  localparam int BIT_IMPRECISE = 10;
  localparam int BIT_PRECISE = 9;
  localparam int BIT_INSTR_FETCH_ERR_FLAG = 8;
  localparam int BIT_MMAV = 7;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [1:0] RST_IRQ = 2'h0;
  localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;
  // interrupt sources: bit 0 pending bus fault activated, bit 1 any flag set
  localparam int IRQ_W = 2;

  // ************************************************************
  // pending imprecise fault state
  // ************************************************************
  typedef enum logic [1:0] {
    PND_IDLE = 2'b00,
    PND_WAIT = 2'b01,
    PND_ACTIVE = 2'b10
  } bfs_pend_type;
endpackage

// >>> logic/bfs_fault_status.sv
/*
  bus fault status flags: imprecise, precise and instruction bus error
  flags, the memory-management address valid flag, the bus fault address
  register and the pending logic for asynchronous bus faults, with an
  avalon-mm slave and a level interrupt.
  assumes the core's fault detectors give one-cycle event pulses on CLK
  and the exception logic supplies priority compare and return signals.
*/
module bfs_fault_status (
  // clock and reset
  input wire logic CLK,
  input wire logic SYS_RST,
  // avalon-mm slave
  input wire logic [3:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  // fault detector events
  input wire logic IMPRECISE_ERR,
  input wire logic PRECISE_ERR,
  input wire logic [31:0] PRECISE_ADDR,
  input wire logic PREFETCH_ERR,
  input wire logic ISSUE_VALID,
  input wire logic MM_FAULT,
  input wire logic [31:0] MM_ADDR,
  // exception context
  input wire logic CTX_ABOVE_BF,
  input wire logic HANDLER_ENTER,
  // fault outputs
  output logic BF_ACTIVATE,
  output logic STACK_PC_FAULTING,
  output logic IRQ
);
  import bfs_pkg::*;

  // ************************************************************
  // flag bank
  // ************************************************************
  bfs_flag_if fif ();
  bfs_flag_bank #(.N(4)) u_bank (
    .clk(CLK),
    .rst(SYS_RST),
    .fif(fif)
  );
  // bank index: 0 imprecise, 1 precise, 2 instr_fetch_err_flag, 3 mm valid
  logic imprecise_bus_err_flag;
  logic precise_err_flag;
  logic instr_fetch_err_flag;
  logic mem_mgmt_addr_valid;
  assign imprecise_bus_err_flag = fif.flags[0];
  assign precise_err_flag = fif.flags[1];
  assign instr_fetch_err_flag = fif.flags[2];
  assign mem_mgmt_addr_valid = fif.flags[3];

  // ************************************************************
  // prefetch error tracking
  // ************************************************************
  logic pf_err;
  logic next_pf_err;
  logic instr_fetch_err_flag_set;
  // error held from prefetch, flagged only when that instruction issues
  always_comb begin
    instr_fetch_err_flag_set = ISSUE_VALID & (pf_err | PREFETCH_ERR);
    next_pf_err = (pf_err | PREFETCH_ERR) & ~ISSUE_VALID;
  end
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      pf_err <= 1'b0;
    end else begin
      pf_err <= next_pf_err;
    end
  end

  // ************************************************************
  // bus decode
  // ************************************************************
  logic wr_hit;
  logic rd_hit;
  logic [31:0] wmask;
  function automatic logic hit(input logic [3:0] a, input logic [3:0] ofs);
    hit = (a == ofs);
  endfunction
  always_comb begin
    wmask = {{8{AVS_BYTEENABLE[3]}}, {8{AVS_BYTEENABLE[2]}},
             {8{AVS_BYTEENABLE[1]}}, {8{AVS_BYTEENABLE[0]}}};
  end
  assign AVS_WAITREQUEST = AVS_READ & ~rd_hit;
  assign wr_hit = AVS_WRITE & hit(AVS_ADDRESS, OFS_FAULT_STAT);

  // flag set and w1c clear strobes; clear writes of zero do nothing
  always_comb begin
    logic [31:0] cw;
    cw = AVS_WRITEDATA & wmask;
    fif.set_evt = {MM_FAULT, instr_fetch_err_flag_set, PRECISE_ERR, IMPRECISE_ERR};
    fif.clr_w1c = 4'h0;
    if (wr_hit) begin
      fif.clr_w1c = {cw[BIT_MMAV], cw[BIT_INSTR_FETCH_ERR_FLAG], cw[BIT_PRECISE], cw[BIT_IMPRECISE]};
    end
  end

  // ************************************************************
  // fault address registers
  // ************************************************************
  logic [31:0] bus_fault_addr_reg;
  logic [31:0] mem_mgmt_fault_addr_reg;
  logic [31:0] next_bf_addr;
  logic [31:0] next_mm_addr;
  // only precise errors load the address; imprecise and instr_fetch_err_flag do not
  always_comb begin
    next_bf_addr = bus_fault_addr_reg;
    next_mm_addr = mem_mgmt_fault_addr_reg;
    if (PRECISE_ERR) begin
      next_bf_addr = PRECISE_ADDR;
    end
    if (MM_FAULT) begin
      next_mm_addr = MM_ADDR;
    end
  end
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      bus_fault_addr_reg <= RST_WORD;
      mem_mgmt_fault_addr_reg <= RST_WORD;
    end else begin
      bus_fault_addr_reg <= next_bf_addr;
      mem_mgmt_fault_addr_reg <= next_mm_addr;
    end
  end

  // stacked return points at faulting instruction for precise errors
  logic stack_pc;
  logic next_stack_pc;
  always_comb begin
    next_stack_pc = PRECISE_ERR;
  end
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      stack_pc <= 1'b0;
    end else begin
      stack_pc <= next_stack_pc;
    end
  end
  assign STACK_PC_FAULTING = stack_pc;

  // ************************************************************
  // pending imprecise fault
  // ************************************************************
  bfs_pend_type pend;
  bfs_pend_type next_pend;
  logic act;
  logic next_act;
  // held while a higher-priority context runs, then activated once
  always_comb begin
    next_pend = pend;
    next_act = 1'b0;
    unique case (pend)
      PND_IDLE: begin
        if (IMPRECISE_ERR) begin
          next_pend = CTX_ABOVE_BF ? PND_WAIT : PND_ACTIVE;
        end
      end
      PND_WAIT: begin
        if (!CTX_ABOVE_BF) begin
          next_pend = PND_ACTIVE;
        end
      end
      PND_ACTIVE: begin
        next_act = 1'b1;
        if (HANDLER_ENTER) begin
          next_pend = PND_IDLE;
          next_act = 1'b0;
        end
      end
      default: begin
        next_pend = PND_IDLE;
      end
    endcase
  end
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      pend <= PND_IDLE;
      act <= 1'b0;
    end else begin
      pend <= next_pend;
      act <= next_act;
    end
  end
  assign BF_ACTIVATE = act;

  // ************************************************************
  // interrupt status, enable and clear
  // ************************************************************
  logic [IRQ_W-1:0] irq_stat;
  logic [IRQ_W-1:0] irq_en;
  logic [IRQ_W-1:0] next_irq_stat;
  logic [IRQ_W-1:0] next_irq_en;
  logic [IRQ_W-1:0] irq_evt;
  always_comb begin
    irq_evt = {|fif.set_evt, (pend != PND_ACTIVE) && (next_pend == PND_ACTIVE)};
    next_irq_stat = irq_stat;
    next_irq_en = irq_en;
    if (AVS_WRITE && hit(AVS_ADDRESS, OFS_IRQ_STAT) && AVS_BYTEENABLE[0]) begin
      next_irq_stat = irq_stat & ~AVS_WRITEDATA[IRQ_W-1:0];
    end
    if (AVS_WRITE && hit(AVS_ADDRESS, OFS_BF_ADDR) && AVS_BYTEENABLE[0]) begin
      next_irq_en = AVS_WRITEDATA[IRQ_W-1:0];
    end
    next_irq_stat = next_irq_stat | irq_evt;
  end
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      irq_stat <= RST_IRQ;
      irq_en <= RST_IRQ;
    end else begin
      irq_stat <= next_irq_stat;
      irq_en <= next_irq_en;
    end
  end
  assign IRQ = |(irq_stat & irq_en);

  // ************************************************************
  // read path: one wait cycle, data from flip-flops
  // ************************************************************
  logic [31:0] rdata;
  logic [31:0] next_rdata;
  logic next_rd_hit;
  always_comb begin
    next_rdata = rdata;
    next_rd_hit = 1'b0;
    if (AVS_READ && !rd_hit) begin
      next_rd_hit = 1'b1;
      next_rdata = UNMAPPED_READ;
      unique case (AVS_ADDRESS)
        OFS_FAULT_STAT: begin
          next_rdata[BIT_IMPRECISE] = imprecise_bus_err_flag;
          next_rdata[BIT_PRECISE] = precise_err_flag;
          next_rdata[BIT_INSTR_FETCH_ERR_FLAG] = instr_fetch_err_flag;
          next_rdata[BIT_MMAV] = mem_mgmt_addr_valid;
        end
        OFS_BF_ADDR: next_rdata = bus_fault_addr_reg;
        OFS_MM_ADDR: next_rdata = mem_mgmt_fault_addr_reg;
        OFS_IRQ_STAT: next_rdata[IRQ_W-1:0] = irq_stat;
        default: next_rdata = UNMAPPED_READ;
      endcase
    end
  end
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      rdata <= RST_WORD;
      rd_hit <= 1'b0;
    end else begin
      rdata <= next_rdata;
      rd_hit <= next_rd_hit;
    end
  end
  assign AVS_READDATA = rdata;

  // ************************************************************
  // checks
  // ************************************************************
  sequence s_imp_high;
    IMPRECISE_ERR && CTX_ABOVE_BF && pend == PND_IDLE;
  endsequence
  a_imp_no_addr: assert property (@(posedge CLK) disable iff (SYS_RST)
    (IMPRECISE_ERR && !PRECISE_ERR |=> $stable(bus_fault_addr_reg)))
    else $error("imprecise error loaded fault address");
  a_pend_hold: assert property (@(posedge CLK) disable iff (SYS_RST)
    (s_imp_high ##1 CTX_ABOVE_BF [*2] |-> !BF_ACTIVATE))
    else $error("pending fault activated early");
  a_both_flags: assert property (@(posedge CLK) disable iff (SYS_RST)
    (imprecise_bus_err_flag && PRECISE_ERR && !wr_hit |=> imprecise_bus_err_flag && precise_err_flag))
    else $error("imprecise and precise not both set");
  a_precise_set: assert property (@(posedge CLK) disable iff (SYS_RST)
    (PRECISE_ERR |=> precise_err_flag && STACK_PC_FAULTING))
    else $error("precise error not flagged");
  a_addr_load: assert property (@(posedge CLK) disable iff (SYS_RST)
    (PRECISE_ERR |=> bus_fault_addr_reg == $past(PRECISE_ADDR)))
    else $error("fault address not loaded");
  a_instr_fetch_err_flag_issue: assert property (@(posedge CLK) disable iff (SYS_RST)
    (PREFETCH_ERR && !ISSUE_VALID && !instr_fetch_err_flag |=> !instr_fetch_err_flag))
    else $error("instr_fetch_err_flag flag set on prefetch");
  a_mmav_read: assert property (@(posedge CLK) disable iff (SYS_RST)
    (AVS_READ && !rd_hit && AVS_ADDRESS == OFS_FAULT_STAT
     |=> AVS_READDATA[BIT_MMAV] == $past(mem_mgmt_addr_valid)))
    else $error("valid flag read wrong");
  a_w1c_clear: assert property (@(posedge CLK) disable iff (SYS_RST)
    (wr_hit && AVS_BYTEENABLE[1] && AVS_WRITEDATA[BIT_IMPRECISE] && !IMPRECISE_ERR
     |=> !imprecise_bus_err_flag))
    else $error("imprecise flag not cleared by one");
endmodule

// >>> logic/bfs_flag_bank.sv
/*
  bank of sticky write-one-to-clear flags. a set in the same cycle as a
  clear wins. assumes set and clear come from the same clock domain.
*/
module bfs_flag_bank #(
  parameter int N = 4
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // flag strobes and state
  bfs_flag_if.bank fif
);
  import bfs_pkg::*;
  logic [N-1:0] flag;
  logic [N-1:0] next_flag;

  // ************************************************************
  // per-flag next value
  // ************************************************************
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_flag
      // set beats clear; writing zero leaves the flag alone
      always_comb begin
        next_flag[g] = fif.set_evt[g] | (flag[g] & ~fif.clr_w1c[g]);
      end
    end
  endgenerate

  // register flags
  always_ff @(posedge clk) begin
    if (rst) begin
      flag <= RST_WORD[N-1:0];
    end else begin
      flag <= next_flag;
    end
  end
  assign fif.flags = flag;

  a_set_holds: assert property (@(posedge clk) disable iff (rst)
    (fif.set_evt[0] |=> flag[0])) else $error("flag not set after event");
  a_stay_set: assert property (@(posedge clk) disable iff (rst)
    (flag[1] && !fif.clr_w1c[1] |=> flag[1])) else $error("flag dropped without clear");
endmodule
